/* hdl/tic_regs.svh */
// Register offsets, field positions and reset values of the timer irq block
`ifndef TIC_REGS_SVH
`define TIC_REGS_SVH
`define TIC_ADDR_CTL   8'h00
`define TIC_ADDR_CLR   8'h04
`define TIC_ADDR_STAT  8'h08
`define TIC_ADDR_MASK  8'h0C
`define TIC_ADDR_MODE  8'h10
`define TIC_PND_LSB    0
`define TIC_EN_LSB     4
`define TIC_CTL_RST    8'h00
`define TIC_SRC_RST    4'h0
`define TIC_RESP_OKAY  2'h0
`define TIC_RESP_SLV   2'h2
`endif

/* hdl/tic_pkg.sv */
// Types shared by the timer interrupt control block
package tic_pkg;
    typedef enum logic [1:0] {
        TIC_MODE_PWM,
        TIC_MODE_DUAL_CAP,
        TIC_MODE_DUAL_TMR,
        TIC_MODE_CAP_TMR
    } tic_mode_t;
    typedef logic [3:0]  tic_src_t;
    typedef logic [7:0]  tic_byte_t;
    typedef logic [15:0] tic_evt_t;
    typedef logic [1:0]  tic_resp_t;
endpackage

/* hdl/tic_if.sv */
// Register access strobes between the bus slave and the register file
`timescale 1ns/1ns
interface tic_if;
    logic      wr_en;
    logic      wr_hit;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic      rd_en;
    logic      rd_hit;
    logic [7:0] rd_addr;
    logic [7:0] rd_data;
    modport slv (output wr_en, wr_addr, wr_data, rd_en, rd_addr,
                 input  wr_hit, rd_hit, rd_data);
    modport regs (input  wr_en, wr_addr, wr_data, rd_en, rd_addr,
                  output wr_hit, rd_hit, rd_data);
endinterface

/* hdl/tic_axil_slave.sv */
// AXI4-Lite slave front end for the timer interrupt registers
`timescale 1ns/1ns
`include "tic_regs.svh"
module tic_axil_slave (
    // Clock and reset
    input  wire logic              ref_clk_i,
    input  wire logic              rst_i,
    // Write address and data
    input  wire logic              s_awvalid_i,
    input  wire logic [7:0]        s_awaddr_i,
    output logic                   s_awready_o,
    input  wire logic              s_wvalid_i,
    input  wire logic [31:0]       s_wdata_i,
    input  wire logic [3:0]        s_wstrb_i,
    output logic                   s_wready_o,
    // Write response
    output logic                   s_bvalid_o,
    output tic_pkg::tic_resp_t     s_bresp_o,
    input  wire logic              s_bready_i,
    // Read
    input  wire logic              s_arvalid_i,
    input  wire logic [7:0]        s_araddr_i,
    output logic                   s_arready_o,
    output logic                   s_rvalid_o,
    output logic [31:0]            s_rdata_o,
    output tic_pkg::tic_resp_t     s_rresp_o,
    input  wire logic              s_rready_i,
    // Register side
    tic_if.slv                     bus
);
    import tic_pkg::*;

    logic       awready_reg, wready_reg, bvalid_reg;
    logic       arready_reg, rvalid_reg;
    logic [7:0] awaddr_reg, wdata_reg;
    logic       wlane_reg;
    tic_resp_t  bresp_reg, rresp_reg;
    logic [31:0] rdata_reg;
    wire        aw_fire = s_awvalid_i & awready_reg;
    wire        w_fire  = s_wvalid_i & wready_reg;
    wire        issue   = ~awready_reg & ~wready_reg & ~bvalid_reg;
    wire        ar_fire = s_arvalid_i & arready_reg;

    // Only byte lane 0 carries register bits
    assign bus.wr_en   = issue & wlane_reg;
    assign bus.wr_addr = awaddr_reg;
    assign bus.wr_data = wdata_reg;
    assign bus.rd_en   = ar_fire;
    assign bus.rd_addr = s_araddr_i;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            awready_reg <= 1'b1;
            wready_reg  <= 1'b1;
            bvalid_reg  <= 1'b0;
            awaddr_reg  <= 8'h00;
            wdata_reg   <= 8'h00;
            wlane_reg   <= 1'b0;
            bresp_reg   <= `TIC_RESP_OKAY;
        end else begin
            if (aw_fire) begin
                awready_reg <= 1'b0;
                awaddr_reg  <= s_awaddr_i;
            end
            if (w_fire) begin
                wready_reg <= 1'b0;
                wdata_reg  <= s_wdata_i[7:0];
                wlane_reg  <= s_wstrb_i[0];
            end
            if (issue) begin
                awready_reg <= 1'b1;
                wready_reg  <= 1'b1;
                bvalid_reg  <= 1'b1;
                bresp_reg   <= bus.wr_hit ? `TIC_RESP_OKAY : `TIC_RESP_SLV;
            end else if (bvalid_reg && s_bready_i) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            arready_reg <= 1'b1;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= 32'h0000_0000;
            rresp_reg   <= `TIC_RESP_OKAY;
        end else if (ar_fire) begin
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b1;
            rdata_reg   <= {24'h000000, bus.rd_data};
            rresp_reg   <= bus.rd_hit ? `TIC_RESP_OKAY : `TIC_RESP_SLV;
        end else if (rvalid_reg && s_rready_i) begin
            arready_reg <= 1'b1;
            rvalid_reg  <= 1'b0;
        end
    end

    assign s_awready_o = awready_reg;
    assign s_wready_o  = wready_reg;
    assign s_bvalid_o  = bvalid_reg;
    assign s_bresp_o   = bresp_reg;
    assign s_arready_o = arready_reg;
    assign s_rvalid_o  = rvalid_reg;
    assign s_rdata_o   = rdata_reg;
    assign s_rresp_o   = rresp_reg;
endmodule // tic_axil_slave

/* hdl/tic_ctrl.sv */
// Timer interrupt pending and enable control with AXI4-Lite registers
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ns
`include "tic_regs.svh"

// Notes on behaviour
// RULE1: One byte register holds enables and pendings
// RULE2: Reset clears the whole control register
// RULE3: Timer mode picks each source's set event
// RULE4: Pending set by hardware event or software one
// RULE5: Pending holds one until cleared
// RULE6: Writing zero to a pending changes nothing
// RULE7: Software clears pendings via clear register only
// RULE8: Enable bit gates each source's interrupt
// RULE9: Pendings in bits 0-3, enables in 4-7
module tic_ctrl (
    // Clock and reset
    input  wire logic              ref_clk_i,
    input  wire logic              rst_i,
    // AXI4-Lite write address and data
    input  wire logic              s_awvalid_i,
    input  wire logic [7:0]        s_awaddr_i,
    output logic                   s_awready_o,
    input  wire logic              s_wvalid_i,
    input  wire logic [31:0]       s_wdata_i,
    input  wire logic [3:0]        s_wstrb_i,
    output logic                   s_wready_o,
    // AXI4-Lite write response
    output logic                   s_bvalid_o,
    output tic_pkg::tic_resp_t     s_bresp_o,
    input  wire logic              s_bready_i,
    // AXI4-Lite read
    input  wire logic              s_arvalid_i,
    input  wire logic [7:0]        s_araddr_i,
    output logic                   s_arready_o,
    output logic                   s_rvalid_o,
    output logic [31:0]            s_rdata_o,
    output tic_pkg::tic_resp_t     s_rresp_o,
    input  wire logic              s_rready_i,
    // Timer trigger conditions, four sources per mode
    input  wire tic_pkg::tic_evt_t timer_evt_i,
    // Interrupt requests
    output logic                   timer_irq_o,
    output logic                   irq_o
);
    import tic_pkg::*;

    tic_if bus ();

    tic_axil_slave u_slave (
        .ref_clk_i   (ref_clk_i),
        .rst_i       (rst_i),
        .s_awvalid_i (s_awvalid_i),
        .s_awaddr_i  (s_awaddr_i),
        .s_awready_o (s_awready_o),
        .s_wvalid_i  (s_wvalid_i),
        .s_wdata_i   (s_wdata_i),
        .s_wstrb_i   (s_wstrb_i),
        .s_wready_o  (s_wready_o),
        .s_bvalid_o  (s_bvalid_o),
        .s_bresp_o   (s_bresp_o),
        .s_bready_i  (s_bready_i),
        .s_arvalid_i (s_arvalid_i),
        .s_araddr_i  (s_araddr_i),
        .s_arready_o (s_arready_o),
        .s_rvalid_o  (s_rvalid_o),
        .s_rdata_o   (s_rdata_o),
        .s_rresp_o   (s_rresp_o),
        .s_rready_i  (s_rready_i),
        .bus         (bus)
    );

    // Register state
    tic_src_t  pend_reg;
    tic_src_t  pend_next;
    tic_src_t  en_reg;
    tic_src_t  en_next;
    tic_src_t  stat_reg;
    tic_src_t  stat_next;
    tic_src_t  mask_reg;
    tic_src_t  mask_next;
    tic_mode_t mode_reg;
    tic_mode_t mode_next;
    logic      timer_irq_reg;
    logic      irq_reg;

    // Address decode, shared by both directions
    function automatic logic is_mapped(input logic [7:0] addr);
        is_mapped = (addr == `TIC_ADDR_CTL)  || (addr == `TIC_ADDR_CLR)
                 || (addr == `TIC_ADDR_STAT) || (addr == `TIC_ADDR_MASK)
                 || (addr == `TIC_ADDR_MODE);
    endfunction

    // Picks the four trigger conditions of the running mode
    function automatic tic_src_t sel_events(input tic_mode_t mode,
                                            input tic_evt_t  evt);
        case (mode)
            TIC_MODE_PWM:      sel_events = evt[3:0];
            TIC_MODE_DUAL_CAP: sel_events = evt[7:4];
            TIC_MODE_DUAL_TMR: sel_events = evt[11:8];
            default:           sel_events = evt[15:12];
        endcase
    endfunction

    assign bus.wr_hit = is_mapped(bus.wr_addr);
    assign bus.rd_hit = is_mapped(bus.rd_addr);

    // Write strobes per register
    wire wr_ctl  = bus.wr_en && (bus.wr_addr == `TIC_ADDR_CTL);
    wire wr_clr  = bus.wr_en && (bus.wr_addr == `TIC_ADDR_CLR);
    wire wr_stat = bus.wr_en && (bus.wr_addr == `TIC_ADDR_STAT);
    wire wr_mask = bus.wr_en && (bus.wr_addr == `TIC_ADDR_MASK);
    wire wr_mode = bus.wr_en && (bus.wr_addr == `TIC_ADDR_MODE);

    wire tic_src_t wr_pnd = bus.wr_data[`TIC_PND_LSB +: 4];
    wire tic_src_t wr_en4 = bus.wr_data[`TIC_EN_LSB +: 4];

    // Hardware trigger chosen by the timer mode
    wire tic_src_t hw_set = sel_events(mode_reg, timer_evt_i); // RULE3

    // Only ones written to the control register set a pending flag
    wire tic_src_t sw_set = wr_ctl ? wr_pnd : `TIC_SRC_RST; // RULE4 RULE6
    wire tic_src_t clr_vec = wr_clr ? wr_pnd : `TIC_SRC_RST; // RULE7

    // Set wins over a clear landing in the same cycle
    assign pend_next = (pend_reg & ~clr_vec) | hw_set | sw_set; // RULE4 RULE5
    assign en_next   = wr_ctl ? wr_en4 : en_reg; // RULE1 RULE9

    // Each occurrence of an enabled condition is an interrupt event
    wire tic_src_t occur = (hw_set | sw_set) & en_next; // RULE8
    wire tic_src_t stat_w1c = wr_stat ? wr_pnd : `TIC_SRC_RST;
    assign stat_next = (stat_reg & ~stat_w1c) | occur;
    assign mask_next = wr_mask ? wr_pnd : mask_reg;
    assign mode_next = wr_mode ? tic_mode_t'(bus.wr_data[1:0]) : mode_reg;

    wire timer_irq_next = |(pend_next & en_next); // RULE8
    wire irq_next       = |(stat_next & mask_next);

    // Read mux; reserved bits and the clear register read as zero
    wire tic_byte_t ctl_val = {en_reg, pend_reg}; // RULE9
    assign bus.rd_data =
        (bus.rd_addr == `TIC_ADDR_CTL)  ? ctl_val :
        (bus.rd_addr == `TIC_ADDR_STAT) ? {4'h0, stat_reg} :
        (bus.rd_addr == `TIC_ADDR_MASK) ? {4'h0, mask_reg} :
        (bus.rd_addr == `TIC_ADDR_MODE) ? {6'h00, mode_reg} :
        8'h00; // RULE1

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pend_reg <= `TIC_SRC_RST; // RULE2
            en_reg   <= `TIC_SRC_RST; // RULE2
        end else begin
            pend_reg <= pend_next;
            en_reg   <= en_next;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            stat_reg <= `TIC_SRC_RST;
            mask_reg <= `TIC_SRC_RST;
            mode_reg <= TIC_MODE_PWM;
        end else begin
            stat_reg <= stat_next;
            mask_reg <= mask_next;
            mode_reg <= mode_next;
        end
    end

    // Requests registered so outputs come straight from flops
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            timer_irq_reg <= 1'b0;
            irq_reg       <= 1'b0;
        end else begin
            timer_irq_reg <= timer_irq_next;
            irq_reg       <= irq_next;
        end
    end

    assign timer_irq_o = timer_irq_reg;
    assign irq_o       = irq_reg;

    // Checks
    default clocking cb @(posedge ref_clk_i); endclocking

    sequence s_ctl_write_zero_pend;
        wr_ctl && (wr_pnd == 4'h0) && !wr_clr;
    endsequence

    sequence s_pend_kept;
        ((pend_reg & $past(pend_reg)) == $past(pend_reg));
    endsequence

    property p_reset_clear;
        @(posedge ref_clk_i) rst_i |-> (ctl_val == `TIC_CTL_RST);
    endproperty
    a_reset_clear: assert property (p_reset_clear) // RULE2
        else $error("control register not cleared in reset");

    property p_ctl_readback;
        disable iff (rst_i)
        (bus.rd_en && bus.rd_addr == `TIC_ADDR_CTL)
            |=> (s_rdata_o == {24'h000000, $past(en_reg), $past(pend_reg)});
    endproperty
    a_ctl_readback: assert property (p_ctl_readback) // RULE1
        else $error("control read does not return enables and pendings");

    property p_mode_event;
        disable iff (rst_i)
        (sel_events(mode_reg, timer_evt_i) != 4'h0)
            |=> ((pend_reg & $past(sel_events(mode_reg, timer_evt_i)))
                 == $past(sel_events(mode_reg, timer_evt_i)));
    endproperty
    a_mode_event: assert property (p_mode_event) // RULE3
        else $error("mode trigger did not set its pending flag");

    property p_sw_set;
        disable iff (rst_i)
        wr_ctl |=> ((pend_reg & $past(wr_pnd)) == $past(wr_pnd));
    endproperty
    a_sw_set: assert property (p_sw_set) // RULE4
        else $error("software one did not set pending flag");

    property p_pend_hold;
        disable iff (rst_i)
        !wr_clr |=> ((pend_reg & $past(pend_reg)) == $past(pend_reg));
    endproperty
    a_pend_hold: assert property (p_pend_hold) // RULE5
        else $error("pending flag dropped without a clear");

    property p_zero_ignored;
        disable iff (rst_i)
        s_ctl_write_zero_pend |=> s_pend_kept;
    endproperty
    a_zero_ignored: assert property (p_zero_ignored) // RULE6
        else $error("writing zero changed a pending flag");

    property p_clear_reg;
        disable iff (rst_i)
        (wr_clr && ((hw_set & wr_pnd) == 4'h0))
            |=> ((pend_reg & $past(wr_pnd)) == 4'h0);
    endproperty
    a_clear_reg: assert property (p_clear_reg) // RULE7
        else $error("clear register did not clear pending flag");

    property p_irq_gate;
        disable iff (rst_i)
        ##1 (timer_irq_o == |($past(pend_next) & $past(en_next)))
            and (|(pend_reg & en_reg) == timer_irq_o);
    endproperty
    a_irq_gate: assert property (p_irq_gate) // RULE8
        else $error("timer request not gated by enables");

    property p_bit_layout;
        disable iff (rst_i)
        wr_ctl |=> (ctl_val[7:4] == $past(bus.wr_data[7:4]))
                   && ((ctl_val[3:0] & $past(wr_pnd)) == $past(wr_pnd));
    endproperty
    a_bit_layout: assert property (p_bit_layout) // RULE9
        else $error("enable bits not taken from bits seven to four");

    property p_status_irq;
        disable iff (rst_i)
        (|(stat_reg & mask_reg)) |-> irq_o;
    endproperty
    a_status_irq: assert property (p_status_irq)
        else $error("unmasked status bit without interrupt");

    property p_reset_irq;
        @(posedge ref_clk_i) rst_i |-> (!timer_irq_o && !irq_o);
    endproperty
    a_reset_irq: assert property (p_reset_irq) // RULE2
        else $error("interrupt request high in reset");

    property p_en_hold;
        disable iff (rst_i)
        !wr_ctl |=> (en_reg == $past(en_reg));
    endproperty
    a_en_hold: assert property (p_en_hold) // RULE1
        else $error("enable bits changed without a control write");

    property p_no_spurious_set;
        disable iff (rst_i)
        1'b1 |=> ((pend_reg & ~$past(pend_reg) & ~$past(hw_set | sw_set))
                  == 4'h0);
    endproperty
    a_no_spurious_set: assert property (p_no_spurious_set) // RULE5
        else $error("pending flag set without an occurrence");

    property p_other_mode_ignored;
        disable iff (rst_i)
        ((timer_evt_i != 16'h0000) && (hw_set == 4'h0) && !wr_ctl)
            |=> ((pend_reg & ~$past(pend_reg)) == 4'h0);
    endproperty
    a_other_mode_ignored: assert property (p_other_mode_ignored) // RULE3
        else $error("trigger of another mode set a pending flag");

    property p_irq_each;
        disable iff (rst_i)
        ((hw_set & en_next) != 4'h0) |=> timer_irq_o;
    endproperty
    a_irq_each: assert property (p_irq_each) // RULE8
        else $error("enabled occurrence gave no timer request");

    property p_irq_off;
        disable iff (rst_i)
        (en_reg == 4'h0) |-> !timer_irq_o;
    endproperty
    a_irq_off: assert property (p_irq_off) // RULE8
        else $error("timer request with every source disabled");

    property p_unmapped_write;
        disable iff (rst_i)
        (bus.wr_en && !bus.wr_hit && (hw_set == 4'h0))
            |=> ((pend_reg == $past(pend_reg)) && (en_reg == $past(en_reg)));
    endproperty
    a_unmapped_write: assert property (p_unmapped_write) // RULE1
        else $error("unmapped write changed the control register");

    property p_stat_set;
        disable iff (rst_i)
        (occur != 4'h0) |=> ((stat_reg & $past(occur)) == $past(occur));
    endproperty
    a_stat_set: assert property (p_stat_set)
        else $error("enabled occurrence did not set its status bit");

    property p_stat_w1c;
        disable iff (rst_i)
        (wr_stat && ((occur & wr_pnd) == 4'h0))
            |=> ((stat_reg & $past(wr_pnd)) == 4'h0);
    endproperty
    a_stat_w1c: assert property (p_stat_w1c)
        else $error("status bit survived a write of one");

    property p_mode_write;
        disable iff (rst_i)
        wr_mode |=> (mode_reg == $past(bus.wr_data[1:0]));
    endproperty
    a_mode_write: assert property (p_mode_write) // RULE3
        else $error("mode register did not take the written value");

    property p_irq_masked;
        disable iff (rst_i)
        ((stat_reg & mask_reg) == 4'h0) |-> !irq_o;
    endproperty
    a_irq_masked: assert property (p_irq_masked)
        else $error("interrupt with no unmasked status bit");

    property p_clr_reads_zero;
        disable iff (rst_i)
        (bus.rd_en && bus.rd_addr == `TIC_ADDR_CLR)
            |=> (s_rdata_o == 32'h00000000);
    endproperty
    a_clr_reads_zero: assert property (p_clr_reads_zero)
        else $error("clear register read back nonzero");
endmodule // tic_ctrl

/* dv/tb.sv */
// Self-checking bench for the timer interrupt control block
`timescale 1ns/1ns
`include "tic_regs.svh"
module tb;
    import tic_pkg::*;
    logic               ref_clk_i;
    logic               rst_i;
    logic               s_awvalid_i;
    logic [7:0]         s_awaddr_i;
    logic               s_awready_o;
    logic               s_wvalid_i;
    logic [31:0]        s_wdata_i;
    logic [3:0]         s_wstrb_i;
    logic               s_wready_o;
    logic               s_bvalid_o;
    tic_resp_t          s_bresp_o;
    logic               s_bready_i;
    logic               s_arvalid_i;
    logic [7:0]         s_araddr_i;
    logic               s_arready_o;
    logic               s_rvalid_o;
    logic [31:0]        s_rdata_o;
    tic_resp_t          s_rresp_o;
    logic               s_rready_i;
    tic_evt_t           timer_evt_i;
    logic               timer_irq_o;
    logic               irq_o;
    int                 err_count;
    int                 comparisons;
    logic [31:0]        rd;
    tic_resp_t          rs;
    tic_evt_t           ev;

    tic_ctrl DUT (
        .ref_clk_i   (ref_clk_i),
        .rst_i       (rst_i),
        .s_awvalid_i (s_awvalid_i),
        .s_awaddr_i  (s_awaddr_i),
        .s_awready_o (s_awready_o),
        .s_wvalid_i  (s_wvalid_i),
        .s_wdata_i   (s_wdata_i),
        .s_wstrb_i   (s_wstrb_i),
        .s_wready_o  (s_wready_o),
        .s_bvalid_o  (s_bvalid_o),
        .s_bresp_o   (s_bresp_o),
        .s_bready_i  (s_bready_i),
        .s_arvalid_i (s_arvalid_i),
        .s_araddr_i  (s_araddr_i),
        .s_arready_o (s_arready_o),
        .s_rvalid_o  (s_rvalid_o),
        .s_rdata_o   (s_rdata_o),
        .s_rresp_o   (s_rresp_o),
        .s_rready_i  (s_rready_i),
        .timer_evt_i (timer_evt_i),
        .timer_irq_o (timer_irq_o),
        .irq_o       (irq_o)
    );

    always #4 ref_clk_i = ~ref_clk_i;

    task automatic check(input logic [31:0] got, input logic [31:0] exp,
                         input string what);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR at %0t ns: %s got %h expected %h",
                     $time, what, got, exp);
        end
    endtask

    task automatic end_sim();
        $display("Counts: %0d comparisons, %0d mismatches",
                 comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Offers address and data together, releases each when taken
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                             output tic_resp_t r);
        int n;
        bit aw;
        bit w;
        bit b;
        n = 0;
        aw = 0;
        w = 0;
        b = 0;
        r = 2'h3;
        s_awvalid_i <= 1'b1;
        s_awaddr_i  <= a;
        s_wvalid_i  <= 1'b1;
        s_wdata_i   <= d;
        s_wstrb_i   <= 4'h1;
        s_bready_i  <= 1'b1;
        while (!b && n < 100) begin
            @(posedge ref_clk_i);
            n++;
            if (!aw && s_awready_o === 1'b1) begin
                aw = 1;
                s_awvalid_i <= 1'b0;
            end
            if (!w && s_wready_o === 1'b1) begin
                w = 1;
                s_wvalid_i <= 1'b0;
            end
            if (aw && w && s_bvalid_o === 1'b1) begin
                b = 1;
                r = s_bresp_o;
                s_bready_i <= 1'b0;
            end
        end
        // Spare edge so a following call never reassigns bready at once
        @(posedge ref_clk_i);
        check({31'h0, b}, 32'h1, "write response");
    endtask

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                            output tic_resp_t r);
        int n;
        bit ar;
        bit got;
        n = 0;
        ar = 0;
        got = 0;
        d = 32'hFFFFFFFF;
        r = 2'h3;
        s_arvalid_i <= 1'b1;
        s_araddr_i  <= a;
        s_rready_i  <= 1'b1;
        while (!got && n < 100) begin
            @(posedge ref_clk_i);
            n++;
            if (!ar && s_arready_o === 1'b1) begin
                ar = 1;
                s_arvalid_i <= 1'b0;
            end
            else if (ar && s_rvalid_o === 1'b1) begin
                got = 1;
                d = s_rdata_o;
                r = s_rresp_o;
                s_rready_i <= 1'b0;
            end
        end
        @(posedge ref_clk_i);
        check({31'h0, got}, 32'h1, "read response");
    endtask

    // One-cycle trigger, then time for pending and irq to land
    task automatic pulse_evt(input tic_evt_t v);
        timer_evt_i <= v;
        @(posedge ref_clk_i);
        timer_evt_i <= 16'h0000;
        repeat (2) @(posedge ref_clk_i);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                          input string what);
        axi_read(a, rd, rs);
        check(rd, exp, what);
        check({30'h0, rs}, {30'h0, `TIC_RESP_OKAY}, "read resp");
    endtask

    initial begin
        ref_clk_i   = 1'b0;
        rst_i       = 1'b1;
        s_awvalid_i = 1'b0;
        s_awaddr_i  = 8'h00;
        s_wvalid_i  = 1'b0;
        s_wdata_i   = 32'h00000000;
        s_wstrb_i   = 4'h0;
        s_bready_i  = 1'b0;
        s_arvalid_i = 1'b0;
        s_araddr_i  = 8'h00;
        s_rready_i  = 1'b0;
        timer_evt_i = 16'h0000;
        err_count   = 0;
        comparisons = 0;
        repeat (8) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        @(posedge ref_clk_i);
        // Reset state
        rd_chk(`TIC_ADDR_CTL, 32'h00000000, "ctl after reset");
        check({31'h0, timer_irq_o}, 32'h0, "timer irq reset");
        check({31'h0, irq_o}, 32'h0, "irq reset");
        rd_chk(`TIC_ADDR_STAT, 32'h00000000, "status reset");
        rd_chk(`TIC_ADDR_MASK, 32'h00000000, "mask reset");
        $display("Test reset done");
        // Software set, ignored zero, clear through the clear register
        axi_write(`TIC_ADDR_CTL, 32'h000000F0, rs);
        check({30'h0, rs}, {30'h0, `TIC_RESP_OKAY}, "write resp");
        rd_chk(`TIC_ADDR_CTL, 32'h000000F0, "enables only");
        check({31'h0, timer_irq_o}, 32'h0, "no pending no irq");
        axi_write(`TIC_ADDR_CTL, 32'h000000F5, rs);
        rd_chk(`TIC_ADDR_CTL, 32'h000000F5, "sw set a c");
        check({31'h0, timer_irq_o}, 32'h1, "enabled pending irq");
        axi_write(`TIC_ADDR_CTL, 32'h000000F0, rs);
        rd_chk(`TIC_ADDR_CTL, 32'h000000F5, "zero write kept");
        axi_write(`TIC_ADDR_CLR, 32'h00000005, rs);
        rd_chk(`TIC_ADDR_CTL, 32'h000000F0, "cleared");
        check({31'h0, timer_irq_o}, 32'h0, "irq after clear");
        rd_chk(`TIC_ADDR_CLR, 32'h00000000, "clear reads zero");
        axi_write(`TIC_ADDR_CTL, 32'h00000000, rs);
        $display("Test software pending done");
        // Each mode takes its own trigger group; others are ignored
        for (int m = 0; m < 4; m++) begin
            axi_write(`TIC_ADDR_MODE, {30'h0, 2'(m)}, rs);
            ev = ~(16'h000F << (4 * m)) | (16'h0001 << (5 * m));
            rd_chk(`TIC_ADDR_MODE, 32'(m), "mode readback");
            pulse_evt(ev ^ (16'h0001 << (5 * m)));
            pulse_evt(ev);
            rd_chk(`TIC_ADDR_CTL, 32'h00000001 << m, "mode event");
            check({31'h0, timer_irq_o}, 32'h0, "disabled irq");
            axi_write(`TIC_ADDR_CLR, 32'h0000000F, rs);
            rd_chk(`TIC_ADDR_CTL, 32'h00000000, "mode clear");
        end
        $display("Test mode triggers done");
        // Status, mask and the summary interrupt
        axi_write(`TIC_ADDR_MODE, 32'h00000000, rs);
        axi_write(`TIC_ADDR_STAT, 32'h0000000F, rs);
        rd_chk(`TIC_ADDR_STAT, 32'h00000000, "status w1c");
        axi_write(`TIC_ADDR_MASK, 32'h00000001, rs);
        axi_write(`TIC_ADDR_CTL, 32'h00000010, rs);
        pulse_evt(16'h0001);
        rd_chk(`TIC_ADDR_CTL, 32'h00000011, "hw set a");
        check({31'h0, timer_irq_o}, 32'h1, "timer irq a");
        rd_chk(`TIC_ADDR_STAT, 32'h00000001, "status a");
        check({31'h0, irq_o}, 32'h1, "irq unmasked");
        axi_write(`TIC_ADDR_MASK, 32'h00000000, rs);
        check({31'h0, irq_o}, 32'h0, "irq masked");
        axi_write(`TIC_ADDR_MASK, 32'h00000001, rs);
        check({31'h0, irq_o}, 32'h1, "irq unmasked again");
        axi_write(`TIC_ADDR_STAT, 32'h00000001, rs);
        check({31'h0, irq_o}, 32'h0, "irq after w1c");
        axi_write(`TIC_ADDR_CLR, 32'h00000001, rs);
        check({31'h0, timer_irq_o}, 32'h0, "timer irq cleared");
        $display("Test status and mask done");
        // Unmapped address: error response, no side effect
        axi_write(8'h20, 32'h000000FF, rs);
        check({30'h0, rs}, {30'h0, `TIC_RESP_SLV}, "unmapped write");
        axi_read(8'h20, rd, rs);
        check({30'h0, rs}, {30'h0, `TIC_RESP_SLV}, "unmapped read");
        check(rd, 32'h00000000, "unmapped data");
        rd_chk(`TIC_ADDR_CTL, 32'h00000010, "ctl untouched");
        $display("Test unmapped done");
        end_sim();
    end

    // Whole run is about two hundred cycles; this bound is generous
    initial begin
        #100000;
        err_count++;
        $display("ERROR at %0t ns: watchdog expired", $time);
        end_sim();
    end
endmodule // tb
